// ---- src/afe_ctrl_pkg.sv ----
// Purpose: Shared constants and carrier types for the optical front-end control register bank.
// Assumes: Byte-wide registers on a plain strobe port, one index per register.
// Notes:   Register indices are local choices; reset values follow the power-on table.
package afe_ctrl_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] SWITCH_MODE_CTRL_IDX          = 3'h0;
    localparam logic [ADDR_W-1:0] FIRST_RESISTOR_SEL_IDX        = 3'h1;
    localparam logic [ADDR_W-1:0] SECOND_THIRD_RESISTOR_SEL_IDX = 3'h2;
    localparam logic [ADDR_W-1:0] AMP_ZERO_CTRL_IDX             = 3'h3;
    localparam logic [ADDR_W-1:0] AMP_ONE_CTRL_IDX              = 3'h4;
    localparam logic [ADDR_W-1:0] AMP_ZERO_OFFSET_CAL_IDX       = 3'h5;
    localparam logic [ADDR_W-1:0] AMP_ONE_OFFSET_CAL_IDX        = 3'h6;

    localparam logic [7:0] SWITCH_MODE_CTRL_RST   = 8'h00;
    localparam logic [7:0] RESISTOR_SEL_RST       = 8'h00;
    localparam logic [7:0] AMP_CTRL_RST           = 8'h00;
    localparam logic [7:0] AMP_OFFSET_CAL_RST     = 8'h20;

    // Writable bit masks; everything outside them reads as zero, except the amplifier status bit.
    localparam logic [7:0] SWITCH_MODE_CTRL_MASK  = 8'h7f;
    localparam logic [7:0] FIRST_RESISTOR_MASK    = 8'h3f;
    localparam logic [7:0] AMP_CTRL_WR_MASK       = 8'h43;

    localparam int SW_FIELD_LSB    = 0;
    localparam int SW_COUNT        = 5;
    localparam int COUPLING_LSB    = 5;
    localparam int R_CODE_LSB      = 0;
    localparam int R3_LSB          = 6;
    localparam int AMP_EN_BIT      = 6;
    localparam int AMP_STATUS_BIT  = 5;
    localparam int AMP_BW_LSB      = 0;
    localparam int CAL_MODE_BIT    = 7;
    localparam int CAL_REF_BIT     = 6;
    localparam int CAL_TRIM_LSB    = 0;

    typedef enum logic [1:0] {
        COUPLE_EXTERNAL,
        COUPLE_AC,
        COUPLE_DC
    } coupling_e;

    typedef struct packed {
        logic       enable;
        logic [1:0] bandwidth;
        logic       cal_mode;
        logic       cal_ref_sel;
        logic [5:0] trim;
    } amp_ctrl_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage : afe_ctrl_pkg

// ---- src/optical_afe_control_regs.sv ----
// Purpose: Register bank steering the switch matrix, resistor ladders and two amplifiers.
// Assumes: Single 20 MHz clock; comparator outputs from the analog side are asynchronous.
// Notes:   All analog controls are registered levels.
//
// Overview of operation
// - Coupling codes 00 and 10 give external, 01 AC, 11 DC coupling.
// - Each of five low switch bits closes its switch when set.
// - Top two bits of the first resistor register always read zero.
// - Six-bit first code sets R1 in steps of one hundred kilohms.
// - Top two bits of second register pick R3 of 10 to 40 kilohms.
// - Each amplifier has enable, two-bit bandwidth and read-only status bit.
// - Each amplifier has calibration mode, reference select and six-bit trim.
// - Low six bits of second register set R2 in hundred-kilohm steps.
// - Bandwidth codes select 5 kHz, 40 kHz, 600 kHz or 2 MHz.
// - Status bit follows amplifier output only in calibration mode, else low.
`timescale 1ns/1ps

module optical_afe_control_regs
    import afe_ctrl_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [DATA_W-1:0]     reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [DATA_W-1:0]     reg_rdata,
    input  wire logic [1:0]            amp_comp_out,
    output logic      [SW_COUNT-1:0]   switch_close,
    output coupling_e                  coupling_mode,
    output logic      [5:0]            first_resistor_code,
    output logic      [5:0]            second_resistor_code,
    output logic      [1:0]            third_resistor_code,
    output amp_ctrl_s                  amp_zero_cfg,
    output amp_ctrl_s                  amp_one_cfg
);

    logic [7:0]  switch_mode_ctrl_reg;
    logic [7:0]  first_resistor_sel_reg;
    logic [7:0]  second_third_resistor_sel_reg;
    logic [7:0]  amp_ctrl_reg [2];
    logic [7:0]  amp_offset_cal_reg [2];
    logic [1:0]  comp_meta_reg;
    logic [1:0]  comp_sync_reg;
    logic [1:0]  amp_status;
    logic [7:0]  rdata_next;
    coupling_e   coupling_next;
    reg_req_s    req;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Switch and resistor registers; reset clears every implemented field.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            switch_mode_ctrl_reg          <= SWITCH_MODE_CTRL_RST;
            first_resistor_sel_reg        <= RESISTOR_SEL_RST;
            second_third_resistor_sel_reg <= RESISTOR_SEL_RST;
        end else if (req.wr) begin
            case (req.addr)
                SWITCH_MODE_CTRL_IDX: begin
                    switch_mode_ctrl_reg <= req.wdata & SWITCH_MODE_CTRL_MASK;
                end
                FIRST_RESISTOR_SEL_IDX: begin
                    first_resistor_sel_reg <= req.wdata & FIRST_RESISTOR_MASK;
                end
                SECOND_THIRD_RESISTOR_SEL_IDX: begin
                    second_third_resistor_sel_reg <= req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Per-amplifier control and calibration registers.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_amp
            localparam logic [ADDR_W-1:0] CTRL_IDX = (g == 0) ? AMP_ZERO_CTRL_IDX : AMP_ONE_CTRL_IDX;
            localparam logic [ADDR_W-1:0] CAL_IDX  = (g == 0) ? AMP_ZERO_OFFSET_CAL_IDX : AMP_ONE_OFFSET_CAL_IDX;

            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    amp_ctrl_reg[g]       <= AMP_CTRL_RST;
                    amp_offset_cal_reg[g] <= AMP_OFFSET_CAL_RST;
                end else if (req.wr) begin
                    if (req.addr == CTRL_IDX) begin
                        amp_ctrl_reg[g] <= req.wdata & AMP_CTRL_WR_MASK;
                    end
                    if (req.addr == CAL_IDX) begin
                        amp_offset_cal_reg[g] <= req.wdata;
                    end
                end
            end

            // The status bit is masked by calibration mode after synchronising.
            assign amp_status[g] = comp_sync_reg[g] & amp_offset_cal_reg[g][CAL_MODE_BIT];
        end
    endgenerate

    // Comparator outputs come from the analog domain and pass two flops.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            comp_meta_reg <= 2'h0;
            comp_sync_reg <= 2'h0;
        end else begin
            comp_meta_reg <= amp_comp_out;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // Read mux; unmapped indices read zero.
    always_comb begin
        rdata_next = 8'h00;
        case (req.addr)
            SWITCH_MODE_CTRL_IDX:          rdata_next = switch_mode_ctrl_reg;
            FIRST_RESISTOR_SEL_IDX:        rdata_next = first_resistor_sel_reg;
            SECOND_THIRD_RESISTOR_SEL_IDX: rdata_next = second_third_resistor_sel_reg;
            AMP_ZERO_CTRL_IDX: begin
                rdata_next = amp_ctrl_reg[0];
                rdata_next[AMP_STATUS_BIT] = amp_status[0];
            end
            AMP_ONE_CTRL_IDX: begin
                rdata_next = amp_ctrl_reg[1];
                rdata_next[AMP_STATUS_BIT] = amp_status[1];
            end
            AMP_ZERO_OFFSET_CAL_IDX:       rdata_next = amp_offset_cal_reg[0];
            AMP_ONE_OFFSET_CAL_IDX:        rdata_next = amp_offset_cal_reg[1];
            default:                       rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Codes 00 and 10 both mean external mode.
    always_comb begin
        case (switch_mode_ctrl_reg[COUPLING_LSB +: 2])
            2'h1:    coupling_next = COUPLE_AC;
            2'h3:    coupling_next = COUPLE_DC;
            default: coupling_next = COUPLE_EXTERNAL;
        endcase
    end

    // Analog controls are registered once more so every output leaves a flop.
    // is software's duty: no interlock here, so a bad write reaches the switch.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            switch_close         <= '0;
            coupling_mode        <= COUPLE_EXTERNAL;
            first_resistor_code  <= 6'h00;
            second_resistor_code <= 6'h00;
            third_resistor_code  <= 2'h0;
            amp_zero_cfg         <= '0;
            amp_one_cfg          <= '0;
        end else begin
            switch_close         <= switch_mode_ctrl_reg[SW_FIELD_LSB +: SW_COUNT];
            coupling_mode        <= coupling_next;
            first_resistor_code  <= first_resistor_sel_reg[R_CODE_LSB +: 6];
            second_resistor_code <= second_third_resistor_sel_reg[R_CODE_LSB +: 6];
            third_resistor_code  <= second_third_resistor_sel_reg[R3_LSB +: 2];
            amp_zero_cfg <= '{enable:      amp_ctrl_reg[0][AMP_EN_BIT],
                              bandwidth:   amp_ctrl_reg[0][AMP_BW_LSB +: 2],
                              cal_mode:    amp_offset_cal_reg[0][CAL_MODE_BIT],
                              cal_ref_sel: amp_offset_cal_reg[0][CAL_REF_BIT],
                              trim:        amp_offset_cal_reg[0][CAL_TRIM_LSB +: 6]};
            amp_one_cfg  <= '{enable:      amp_ctrl_reg[1][AMP_EN_BIT],
                              bandwidth:   amp_ctrl_reg[1][AMP_BW_LSB +: 2],
                              cal_mode:    amp_offset_cal_reg[1][CAL_MODE_BIT],
                              cal_ref_sel: amp_offset_cal_reg[1][CAL_REF_BIT],
                              trim:        amp_offset_cal_reg[1][CAL_TRIM_LSB +: 6]};
        end
    end

endmodule : optical_afe_control_regs

// ---- verification/afe_regs_props.sv ----
// Purpose: Port-level checks for the optical front-end register bank.
// Assumes: A write reaches the analog outputs one edge after its strobe edge and is sampled there at the second.
// Notes:   Status checks skip reads right after a write, where outputs still lag.
`timescale 1ns/1ps
module afe_regs_props
    import afe_ctrl_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [2:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [4:0]  switch_close,
    input coupling_e        coupling_mode,
    input wire logic [5:0]  first_resistor_code,
    input wire logic [5:0]  second_resistor_code,
    input wire logic [1:0]  third_resistor_code,
    input amp_ctrl_s        amp_zero_cfg,
    input amp_ctrl_s        amp_one_cfg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [7:0] wd_q;
    logic [7:0] wd_qq;
    always_ff @(posedge clk_sys) begin
        wd_q  <= reg_wdata;
        wd_qq <= wd_q;
    end
    property p_sw; reg_wr && reg_addr == 3'h0 |-> ##2 switch_close == wd_qq[4:0]; endproperty
    a_sw: assert property (p_sw) else $error("switch output mismatch");
    property p_cpl;
        reg_wr && reg_addr == 3'h0 |-> ##2 coupling_mode == coupling_e'({&wd_qq[6:5], !wd_qq[6] && wd_qq[5]});
    endproperty
    a_cpl: assert property (p_cpl) else $error("coupling mismatch");
    property p_r1; reg_wr && reg_addr == 3'h1 |-> ##2 first_resistor_code == wd_qq[5:0]; endproperty
    a_r1: assert property (p_r1) else $error("first code mismatch");
    property p_r23;
        reg_wr && reg_addr == 3'h2 |-> ##2 {third_resistor_code, second_resistor_code} == wd_qq;
    endproperty
    a_r23: assert property (p_r23) else $error("second or third code mismatch");
    property p_a0; reg_wr && reg_addr == 3'h3 |-> ##2 {amp_zero_cfg[10:8]} == {wd_qq[6], wd_qq[1:0]}; endproperty
    a_a0: assert property (p_a0) else $error("amp zero control mismatch");
    property p_c1; reg_wr && reg_addr == 3'h6 |-> ##2 amp_one_cfg[7:0] == wd_qq; endproperty
    a_c1: assert property (p_c1) else $error("amp one calibration mismatch");
    property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_r1rd; reg_rd && reg_addr == 3'h1 |=> reg_rdata[7:6] == 2'b00; endproperty
    a_r1rd: assert property (p_r1rd) else $error("unimplemented bits read high");
    property p_st;
        reg_rd && reg_addr == 3'h3 && !amp_zero_cfg.cal_mode && !$past(reg_wr) |=> (reg_rdata & 8'hbc) == 8'h00;
    endproperty
    a_st: assert property (p_st) else $error("status high outside calibration");
endmodule : afe_regs_props
bind optical_afe_control_regs afe_regs_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switch_close(switch_close),
    .coupling_mode(coupling_mode), .first_resistor_code(first_resistor_code), .amp_one_cfg(amp_one_cfg),
    .second_resistor_code(second_resistor_code), .third_resistor_code(third_resistor_code),
    .amp_zero_cfg(amp_zero_cfg));

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the optical front-end register bank.
// Assumes: Strobes launched after a rising edge, read data sampled after the next.
// Notes:   One compare task packs every result into a 24-bit value.
`timescale 1ns/1ps
module testbench;
    import afe_ctrl_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [1:0]  amp_comp_out = 2'b00;
    logic [7:0]  reg_rdata;
    logic [4:0]  switch_close;
    coupling_e   coupling_mode;
    logic [5:0]  r1_code;
    logic [5:0]  r2_code;
    logic [1:0]  r3_code;
    amp_ctrl_s   amp_zero_cfg;
    amp_ctrl_s   amp_one_cfg;
    int          n_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [7:0]  got;
    always #25 clk_sys = ~clk_sys;
    optical_afe_control_regs DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .amp_comp_out(amp_comp_out),
        .switch_close(switch_close), .coupling_mode(coupling_mode), .first_resistor_code(r1_code),
        .second_resistor_code(r2_code), .third_resistor_code(r3_code), .amp_zero_cfg(amp_zero_cfg),
        .amp_one_cfg(amp_one_cfg));
    task automatic chk(input logic [23:0] exp, input logic [23:0] act);
        checks++;
        if (act !== exp) begin
            n_errors++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, act);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
    endtask : rd
    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0]);
            chk((i == 5 || i == 6) ? 24'h20 : 24'h0, got);
        end
        chk(24'h0, {switch_close, coupling_mode, r1_code, r2_code, r3_code});
        $display("test reset done");
    endtask : t_reset
    task automatic t_switch;
        logic [4:0] sw;
        for (int c = 0; c < 4; c++) begin
            sw = (c == 3) ? 5'h1d : 5'h12 ^ {3'b0, c[1:0]};
            wr(3'h0, {1'b1, c[1:0], sw});
            settle;
            chk({sw, (c == 3) ? 2'd2 : (c == 1) ? 2'd1 : 2'd0}, {switch_close, coupling_mode});
            rd(3'h0);
            chk({1'b0, c[1:0], sw}, got);
        end
        $display("test switch done");
    endtask : t_switch
    task automatic t_resist;
        wr(3'h1, 8'hff);
        rd(3'h1);
        chk(24'h3f, got);
        chk(24'h3f, r1_code);
        for (int r = 0; r < 4; r++) begin
            wr(3'h2, {r[1:0], 6'h2a >> r});
            settle;
            chk({r[1:0], 6'h2a >> r}, {r3_code, r2_code});
        end
        $display("test resistor done");
    endtask : t_resist
    task automatic t_amp;
        amp_comp_out <= 2'b11;
        wr(3'h3, 8'hff);
        rd(3'h3);
        chk(24'h43, got);
        chk(24'h7, amp_zero_cfg[10:8]);
        for (int b = 0; b < 4; b++) begin
            wr(3'h4, {6'h0, b[1:0]});
            settle;
            chk({1'b0, b[1:0]}, amp_one_cfg[10:8]);
        end
        wr(3'h6, 8'h95);
        wr(3'h5, 8'hc7);
        settle;
        chk(24'h95c7, {amp_one_cfg[7:0], amp_zero_cfg[7:0]});
        rd(3'h3);
        chk(24'h63, got);
        amp_comp_out <= 2'b01;
        repeat (3) settle;
        rd(3'h4);
        chk(24'h03, got);
        amp_comp_out <= 2'b10;
        repeat (3) settle;
        rd(3'h4);
        chk(24'h23, got);
        rd(3'h3);
        chk(24'h43, got);
        wr(3'h7, 8'hff);
        rd(3'h7);
        chk(24'h0, got);
        $display("test amplifier done");
    endtask : t_amp
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            conclude;
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_switch;
        t_resist;
        t_amp;
        conclude;
    end
endmodule : testbench
